// ---- core/flrpp_dev.sv ----
`timescale 1ns/1ns
// Memory controller end: control bits, step tracking, protection and standby
module flrpp_dev import flrpp_pkg::*; #(
   parameter logic [15:0] PROT_BYTE_ADDR = PROT_BYTE_ADDR_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   flrpp_if.dev             lnk,
   input  wire logic [7:0]  protect_start_bits,
   input  wire logic        test_voltage_level,
   output logic             arr_pgm,
   output logic             arr_erase,
   output logic             arr_mass,
   output logic             arr_hv,
   output logic             arr_prog_stb,
   output logic [15:0]      arr_addr,
   output logic [7:0]       arr_data,
   output logic             standby,
   output logic             hv_refused
);
   typedef struct packed {
      flrpp_dst_e  st;
      logic        program_select;
      logic        erase;
      logic        mass;
      logic        hv;
      logic        standby;
      logic        refused;
      logic        prog_stb;
      logic        prot_vld;
      logic [7:0]  prot_data;
      logic [15:0] lat_addr;
      logic [15:0] pa;
      logic [7:0]  pd;
   } flrpp_dev_s;

   flrpp_dev_s  q;
   flrpp_dev_s  d;
   logic        blocked;
   logic [15:0] chk_addr;
   logic        want_p;
   logic        want_e;
   logic        want_hv;

   // Pump check uses the latched target, byte writes use their own address
   assign chk_addr = (q.st == D_HV) ? lnk.arr_addr : q.lat_addr;

   flrpp_prot_chk #(
      .PROT_BYTE_ADDR (PROT_BYTE_ADDR)
   ) u_prot (
      .bpr     (protect_start_bits),
      .tst     (test_voltage_level),
      .mass    (q.mass & q.erase),
      .addr    (chk_addr),
      .blocked (blocked)
   );

   assign want_p  = lnk.ctl_wdata[CTL_PGM];
   assign want_e  = lnk.ctl_wdata[CTL_ERASE];
   assign want_hv = lnk.ctl_wdata[CTL_HV];

   // Next state of the whole controller
   always_comb begin
      d          = q;
      d.prog_stb = 1'b0;
      d.refused  = 1'b0;
      d.prot_vld = 1'b0;

      // Protect byte lives in the array; only a read path exists here
      if (lnk.prot_rd) begin
         d.prot_vld  = 1'b1;
         d.prot_data = protect_start_bits;
         if (q.st == D_SEL) d.st = D_PRD;
      end

      if (lnk.arr_wr) begin
         if (q.st == D_PRD) begin
            d.lat_addr = lnk.arr_addr;
            d.st       = D_LAT;
         end else if (q.st == D_HV && q.program_select && !blocked &&
                      lnk.arr_addr[15:ROW_BITS] == q.lat_addr[15:ROW_BITS]) begin
            d.prog_stb = 1'b1;
            d.pa       = lnk.arr_addr;
            d.pd       = lnk.arr_wdata;
         end
      end
      // Address output is its own flop: byte address while strobing, else the latched row
      if (!d.prog_stb) d.pa = d.lat_addr;

      if (lnk.ctl_wr) begin
         // A select is refused while the other is set or requested with it
         d.program_select     = want_p & ~want_e & ~q.erase;
         d.erase   = want_e & ~want_p & ~q.program_select;
         d.mass    = lnk.ctl_wdata[CTL_MASS];
         d.standby = 1'b0;
         if (want_hv && !q.hv) begin
            // Early or protected requests leave the pump off and flag it
            if (q.st == D_LAT && (d.program_select | d.erase) && !blocked) begin
               d.hv = 1'b1;
               d.st = D_HV;
            end else begin
               d.refused = 1'b1;
            end
         end else if (!want_hv) begin
            d.hv = 1'b0;
         end
         if (!d.program_select && !d.erase) begin
            d.st = d.hv ? D_HOLD : D_IDLE;
         end else if (q.st == D_IDLE && !d.hv) begin
            d.st = D_SEL;
         end
      end

      // Low power mid operation drops everything; array sees only idle controls
      if (lnk.low_power && (q.program_select | q.erase | q.hv)) begin
         d.program_select      = 1'b0;
         d.erase    = 1'b0;
         d.mass     = 1'b0;
         d.hv       = 1'b0;
         d.prog_stb = 1'b0;
         d.st       = D_IDLE;
         d.standby  = 1'b1;
      end
   end

   // Single state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Array controls and link answers, all from flops
   assign arr_pgm                  = q.program_select;
   assign arr_erase                = q.erase;
   assign arr_mass                 = q.mass;
   assign arr_hv                   = q.hv;
   assign arr_prog_stb             = q.prog_stb;
   assign arr_addr                 = q.pa;
   assign arr_data                 = q.pd;
   assign standby                  = q.standby;
   assign hv_refused               = q.refused;
   // One driver for the whole word; order is pump, mass, erase, program from the top
   assign lnk.ctl_rdata            = {q.hv, q.mass, q.erase, q.program_select};
   assign lnk.prot_vld             = q.prot_vld;
   assign lnk.prot_rdata           = q.prot_data;
endmodule : flrpp_dev

// ---- core/flrpp_host.sv ----
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
// Sequencing end: Avalon-MM slave that walks the ordered program and erase steps
module flrpp_host import flrpp_pkg::*; #(
   parameter int T_ERASE      = T_ERASE_CYC,
   parameter int T_MERASE     = T_MERASE_CYC,
   parameter int T_NVHL       = T_NVHL_CYC,
   parameter int BYTE_PROGRAM_TIME_MAX   = BYTE_PROGRAM_TIME_MAX_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        low_power_req,
   flrpp_if.host            lnk
);
   if (BYTE_PROGRAM_TIME_MAX <= BYTE_PROGRAM_TIME_CYC || T_ERASE >= 2**CNT_W || T_MERASE >= 2**CNT_W ||
       T_NVHL >= 2**CNT_W || BYTE_PROGRAM_TIME_MAX >= 2**CNT_W || T_ERASE < 1 || T_MERASE < 1 ||
       T_NVHL < HV_HOLD_DELAY_CYC) begin : g_chk
      $error("flrpp_host: timing parameter out of range");
   end

   localparam logic [CNT_W-1:0] DATA_WAIT = CNT_W'(BYTE_PROGRAM_TIME_MAX - BYTE_PROGRAM_TIME_CYC);

   typedef struct packed {
      flrpp_hst_e       st;
      logic [1:0]       op;
      logic [15:0]      addr;
      logic [4:0]       left;
      logic [CNT_W-1:0] cnt;
      logic [CTL_W-1:0] ctl;
      logic             ctl_wr;
      logic             prot_rd;
      logic             arr_wr;
      logic [15:0]      arr_addr;
      logic [7:0]       arr_wdata;
      logic             low_power;
      logic             refused;
      logic             done;
      logic             abort;
      logic [7:0]       prot_byte;
      logic             waitreq;
      logic [31:0]      rdata;
   } flrpp_host_s;

   flrpp_host_s q;
   flrpp_host_s d;

   always_comb begin
      d           = q;
      d.ctl_wr    = 1'b0;
      d.prot_rd   = 1'b0;
      d.arr_wr    = 1'b0;
      d.waitreq   = 1'b1;
      d.low_power = low_power_req;
      // Step sequencer; each timed wait counts down to zero, the protect wait holds for prot_vld
      unique case (q.st)
         H_IDLE: ;
         H_SEL: begin
            d.ctl         = '0;
            d.ctl[CTL_PGM]   = (q.op == OP_PROG);
            d.ctl[CTL_ERASE] = (q.op != OP_PROG);
            d.ctl[CTL_MASS]  = (q.op == OP_MASS);
            d.ctl_wr      = 1'b1;
            d.st          = H_PRD;
         end
         H_PRD: begin
            d.prot_rd = 1'b1;
            d.st      = H_PRW;
         end
         H_PRW: if (lnk.prot_vld) begin
            d.prot_byte = lnk.prot_rdata;
            d.st        = H_LAT;
         end
         H_LAT: begin
            d.arr_wr   = 1'b1;
            d.arr_addr = q.addr;
            d.cnt      = CNT_W'(HV_SETUP_DELAY_CYC);
            d.st       = H_NVS;
         end
         H_NVS: if (q.cnt == '0) d.st = H_HVON; else d.cnt = q.cnt - 1'b1;
         H_HVON: begin
            d.ctl[CTL_HV] = 1'b1;
            d.ctl_wr      = 1'b1;
            d.cnt         = CNT_W'(1);
            d.st          = H_CHK;
         end
         H_CHK: begin
            // One spare cycle lets the device answer the pump write
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else if (!lnk.ctl_rdata[CTL_HV]) begin
               d.refused = 1'b1;
               d.st      = H_CLRHV;
            end else begin
               d.cnt = (q.op == OP_PROG) ? CNT_W'(PROGRAM_SETUP_DELAY_CYC) :
                       (q.op == OP_PAGE) ? CNT_W'(T_ERASE) : CNT_W'(T_MERASE);
               d.st  = H_HVW;
            end
         end
         H_HVW: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else if (q.op == OP_PROG) begin
               d.cnt = DATA_WAIT;
               d.st  = H_DATA;
            end else begin
               d.st = H_CLRSEL;
            end
         end
         H_DATA: begin
            // Software too slow with the next byte ends the row early
            if (q.cnt == '0) begin
               d.refused = 1'b1;
               d.st      = H_CLRSEL;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end
         H_PROG: begin
            if (q.cnt != '0) begin
               d.cnt = q.cnt - 1'b1;
            end else if (q.left == '0) begin
               d.st = H_CLRSEL;
            end else begin
               d.left = q.left - 1'b1;
               d.cnt  = DATA_WAIT;
               d.st   = H_DATA;
            end
         end
         H_CLRSEL: begin
            d.ctl[CTL_PGM]   = 1'b0;
            d.ctl[CTL_ERASE] = 1'b0;
            d.ctl[CTL_MASS]  = 1'b0;
            d.ctl_wr         = 1'b1;
            d.cnt            = (q.op == OP_MASS) ? CNT_W'(T_NVHL) : CNT_W'(HV_HOLD_DELAY_CYC);
            d.st             = H_NVH;
         end
         H_NVH: if (q.cnt == '0) d.st = H_CLRHV; else d.cnt = q.cnt - 1'b1;
         H_CLRHV: begin
            d.ctl    = '0;
            d.ctl_wr = 1'b1;
            d.cnt    = CNT_W'(READ_RECOVERY_DELAY_CYC);
            d.st     = H_RCV;
         end
         H_RCV: begin
            if (q.cnt == '0) begin
               d.done = 1'b1;
               d.st   = H_IDLE;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end
      endcase

      // Bus slave; status reads are served during any step
      if ((avs_read || avs_write) && q.waitreq) begin
         if (avs_read) begin
            d.waitreq = 1'b0;
            d.rdata   = '0;
            unique case (avs_address)
               REG_CMD: begin
                  d.rdata[CMD_OP_LSB +: 2]  = q.op;
                  d.rdata[CMD_CNT_LSB +: 5] = q.left;
               end
               REG_ADDR: d.rdata[15:0] = q.addr;
               REG_STATUS: begin
                  d.rdata[ST_BUSY]          = (q.st != H_IDLE);
                  d.rdata[ST_REFUSED]       = q.refused;
                  d.rdata[ST_DONE]          = q.done;
                  d.rdata[ST_ABORT]         = q.abort;
                  d.rdata[ST_PROT_LSB +: 8] = q.prot_byte;
               end
               default: ;
            endcase
         end else if (avs_address == REG_DATA && q.st != H_IDLE) begin
            // Byte writes stall until the sequencer wants the next byte
            if (q.st == H_DATA) begin
               d.waitreq   = 1'b0;
               d.arr_wr    = 1'b1;
               d.arr_addr  = q.addr;
               d.arr_wdata = avs_writedata[7:0];
               d.addr      = q.addr + 16'h0001;
               d.cnt       = CNT_W'(BYTE_PROGRAM_TIME_CYC);
               d.st        = H_PROG;
            end
         end else begin
            d.waitreq = 1'b0;
            if (q.st == H_IDLE && avs_address == REG_ADDR) d.addr = avs_writedata[15:0];
            if (q.st == H_IDLE && avs_address == REG_CMD) begin
               d.op      = avs_writedata[CMD_OP_LSB +: 2];
               d.left    = avs_writedata[CMD_CNT_LSB +: 5];
               d.refused = 1'b0;
               d.done    = 1'b0;
               d.abort   = 1'b0;
               if (d.op == 2'h3 || (d.op == OP_PROG &&
                   ({1'b0, q.addr[4:0]} + {1'b0, d.left}) > 6'(ROW_LAST))) begin
                  d.refused = 1'b1;
                  d.done    = 1'b1;
               end else begin
                  d.st = H_SEL;
               end
            end
         end
      end

      // Low power request abandons the sequence; device drops to standby if a select or the pump is set
      if (low_power_req && q.st != H_IDLE) begin
         d.abort = 1'b1;
         d.done  = 1'b1;
         d.ctl   = '0;
         d.st    = H_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q         <= '0;
         q.waitreq <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.waitreq;
   assign lnk.ctl_wr      = q.ctl_wr;
   assign lnk.ctl_wdata   = q.ctl;
   assign lnk.prot_rd     = q.prot_rd;
   assign lnk.arr_wr      = q.arr_wr;
   assign lnk.arr_addr    = q.arr_addr;
   assign lnk.arr_wdata   = q.arr_wdata;
   assign lnk.low_power   = q.low_power;
endmodule : flrpp_host

// ---- core/flrpp_if.sv ----
`timescale 1ns/1ns
// Link between the sequencing host and the memory controller
interface flrpp_if import flrpp_pkg::*; ;
   logic             ctl_wr;
   logic [CTL_W-1:0] ctl_wdata;
   logic [CTL_W-1:0] ctl_rdata;
   logic             prot_rd;
   logic             prot_vld;
   logic [7:0]       prot_rdata;
   logic             arr_wr;
   logic [15:0]      arr_addr;
   logic [7:0]       arr_wdata;
   logic             low_power;
   modport host (output ctl_wr, ctl_wdata, prot_rd, arr_wr, arr_addr, arr_wdata, low_power,
                 input  ctl_rdata, prot_vld, prot_rdata);
   modport dev  (input  ctl_wr, ctl_wdata, prot_rd, arr_wr, arr_addr, arr_wdata, low_power,
                 output ctl_rdata, prot_vld, prot_rdata);
endinterface : flrpp_if

// ---- core/flrpp_pkg.sv ----
package flrpp_pkg;
   // Clock and delays
   localparam int CLK_NS          = 8;
   localparam int HV_SETUP_DELAY_NS        = 10000;
   localparam int PROGRAM_SETUP_DELAY_NS        = 5000;
   localparam int BYTE_PROGRAM_TIME_NS       = 30000;
   localparam int HV_HOLD_DELAY_NS        = 5000;
   localparam int READ_RECOVERY_DELAY_NS        = 1000;
   localparam int T_NVHL_NS       = 100000;
   localparam int T_ERASE_NS      = 4000000;
   localparam int T_MERASE_NS     = 4000000;
   localparam int BYTE_PROGRAM_TIME_MAX_NS   = 40000;
   localparam int HV_SETUP_DELAY_CYC       = (HV_SETUP_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROGRAM_SETUP_DELAY_CYC       = (PROGRAM_SETUP_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int BYTE_PROGRAM_TIME_CYC      = (BYTE_PROGRAM_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int HV_HOLD_DELAY_CYC       = (HV_HOLD_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_RECOVERY_DELAY_CYC       = (READ_RECOVERY_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_NVHL_CYC      = (T_NVHL_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ERASE_CYC     = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_MERASE_CYC    = (T_MERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int BYTE_PROGRAM_TIME_MAX_CYC  = BYTE_PROGRAM_TIME_MAX_NS / CLK_NS;
   localparam int CNT_W           = 20;
   // Control word bits on the link
   localparam int CTL_W           = 4;
   localparam int CTL_PGM         = 0;
   localparam int CTL_ERASE       = 1;
   localparam int CTL_MASS        = 2;
   localparam int CTL_HV          = 3;
   // Array geometry and protect codes
   localparam int ROW_BITS        = 5;
   localparam int ROW_LAST        = 31;
   localparam logic [1:0] PROT_HI = 2'h3;
   localparam logic [5:0] PROT_LO = 6'h00;
   localparam logic [7:0] BPR_ALL_PROT = 8'h00;
   localparam logic [7:0] BPR_ALL_OPEN = 8'hFF;
   localparam logic [7:0] BPR_VEC_ONLY = 8'hFE;
   localparam logic [15:0] PROT_BYTE_ADDR_DEF = 16'hFF7E;
   // Host register map (byte addresses) and fields
   localparam logic [3:0] REG_CMD    = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_DATA   = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_CNT_LSB = 8;
   localparam logic [1:0] OP_PROG = 2'h0;
   localparam logic [1:0] OP_PAGE = 2'h1;
   localparam logic [1:0] OP_MASS = 2'h2;
   localparam int ST_BUSY     = 0;
   localparam int ST_REFUSED  = 1;
   localparam int ST_DONE     = 2;
   localparam int ST_ABORT    = 3;
   localparam int ST_PROT_LSB = 8;
   typedef enum logic [2:0] {D_IDLE, D_SEL, D_PRD, D_LAT, D_HV, D_HOLD} flrpp_dst_e;
   typedef enum logic [3:0] {H_IDLE, H_SEL, H_PRD, H_PRW, H_LAT, H_NVS, H_HVON, H_CHK,
                             H_HVW, H_DATA, H_PROG, H_CLRSEL, H_NVH, H_CLRHV, H_RCV} flrpp_hst_e;
endpackage : flrpp_pkg

// ---- core/flrpp_prot_chk.sv ----
`timescale 1ns/1ns
module flrpp_prot_chk import flrpp_pkg::*; #(
   parameter logic [15:0] PROT_BYTE_ADDR = PROT_BYTE_ADDR_DEF
) (
   input  wire logic [7:0]  bpr,
   input  wire logic        tst,
   input  wire logic        mass,
   input  wire logic [15:0] addr,
   output logic             blocked
);
   logic [15:0] start;

   assign start = {PROT_HI, bpr, PROT_LO};

   // Range runs from start to the top of memory
   always_comb begin
      blocked = 1'b0;
      if (!tst) begin
         if (bpr == BPR_ALL_PROT) begin
            blocked = 1'b1;
         end else if (bpr != BPR_ALL_OPEN) begin
            if (addr >= start) blocked = 1'b1;
            if (mass) blocked = 1'b1;
            if (bpr != BPR_VEC_ONLY && addr == PROT_BYTE_ADDR) blocked = 1'b1;
         end
      end
   end
endmodule : flrpp_prot_chk

// ---- testbench/flrpp_link_chk.sv ----
`timescale 1ns/1ns
// Watches the link between the sequencing host and the memory controller
module flrpp_link_chk import flrpp_pkg::*; (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             ctl_wr,
   input wire logic [CTL_W-1:0] ctl_wdata,
   input wire logic [CTL_W-1:0] ctl_rdata,
   input wire logic             prot_rd,
   input wire logic             prot_vld,
   input wire logic             arr_wr,
   input wire logic             low_power
);
   logic             prd_q;
   logic             lat_q;
   logic             byte_q;
   logic             hv_q;
   logic [CNT_W-1:0] ev_q;
   logic [CNT_W-1:0] off_q;
   wire              sel = ctl_rdata[CTL_PGM] | ctl_rdata[CTL_ERASE];
   wire              hv  = ctl_rdata[CTL_HV];
   // Step flags restart on any control write without the pump bit
   always_ff @(posedge clk) begin
      if (!rst_n || (ctl_wr && !ctl_wdata[CTL_HV])) begin
         prd_q  <= 1'b0;
         lat_q  <= 1'b0;
         byte_q <= 1'b0;
      end else begin
         if (prot_rd) prd_q <= 1'b1;
         if (arr_wr && prd_q) lat_q <= 1'b1;
         if (arr_wr && hv) byte_q <= 1'b1;
      end
   end
   // Counters saturate so a long idle never wraps into a false pass
   always_ff @(posedge clk) begin
      hv_q <= rst_n & hv;
      if (!rst_n || arr_wr || (hv && !hv_q)) ev_q <= '0;
      else if (ev_q != '1) ev_q <= ev_q + 1'b1;
      if (!rst_n || sel) off_q <= '0;
      else if (off_q != '1) off_q <= off_q + 1'b1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   prot_answer_a: assert property (prot_rd |=> prot_vld) else $error("protect answer missing");
   prot_cause_a: assert property (prot_vld |-> $past(prot_rd)) else $error("protect answer unasked");
   sel_lock_a: assert property (!(ctl_rdata[CTL_PGM] && ctl_rdata[CTL_ERASE])) else $error("both selects");
   hv_sel_a: assert property ($rose(hv) |-> $past(sel)) else $error("pump without select");
   hv_order_a: assert property ($rose(hv) |-> lat_q) else $error("pump out of order");
   hv_setup_a: assert property ($rose(hv) |-> ev_q >= HV_SETUP_DELAY_CYC) else $error("pump setup short");
   pgm_setup_a: assert property (arr_wr && hv |-> ev_q >= PROGRAM_SETUP_DELAY_CYC) else $error("program setup short");
   byte_gap_a: assert property (arr_wr && hv && byte_q |-> ev_q >= BYTE_PROGRAM_TIME_CYC) else $error("byte gap short");
   hv_hold_a: assert property ($fell(hv) && !$past(low_power) |-> off_q >= HV_HOLD_DELAY_CYC - 2)
      else $error("pump hold short");
   abort_a: assert property (low_power && ctl_rdata != '0 |=> ctl_rdata == '0) else $error("abort kept bits");
   cover property ($rose(hv));
   cover property (arr_wr && hv && byte_q);
   cover property (low_power && sel);
endmodule : flrpp_link_chk

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   import flrpp_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        low_power_req = 1'b0;
   logic [7:0]  bpr = 8'hFF;
   logic        tst = 1'b0;
   logic        arr_pgm, arr_erase, arr_mass, arr_hv, arr_prog_stb, standby, hv_refused;
   logic [15:0] arr_addr, stb_a;
   logic [7:0]  arr_data, stb_d;
   logic [31:0] q;
   logic [27:0] c;
   int          n_fail = 0, cmp_count = 0, n_stb = 0, n_ref = 0, e_stb = 0, e_ref = 0;
   // Protect byte, test voltage, op, target address, refusal expected
   localparam logic [27:0] CASES [9] = '{
      {8'h00, 1'b0, OP_PAGE, 16'h2000, 1'b1}, {8'h00, 1'b1, OP_PROG, 16'h2000, 1'b0},
      {8'h01, 1'b0, OP_PROG, 16'hC03F, 1'b0}, {8'h01, 1'b0, OP_PROG, 16'hC040, 1'b1},
      {8'hFD, 1'b0, OP_PROG, 16'hFF7E, 1'b1}, {8'hFE, 1'b0, OP_PROG, 16'hFF7E, 1'b0},
      {8'hFE, 1'b0, OP_PROG, 16'hFF80, 1'b1}, {8'hFE, 1'b0, OP_MASS, 16'h0000, 1'b1},
      {8'hFF, 1'b0, OP_MASS, 16'h0000, 1'b0}};
   always #4 clk = ~clk;
   flrpp_if lnk ();
   flrpp_host #(.T_ERASE(200), .T_MERASE(200), .T_NVHL(700), .BYTE_PROGRAM_TIME_MAX(4000)) u_flrpp_host (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .low_power_req(low_power_req), .lnk(lnk));
   flrpp_dev u_flrpp_dev (
      .clk(clk), .rst_n(rst_n), .lnk(lnk), .protect_start_bits(bpr), .test_voltage_level(tst),
      .arr_pgm(arr_pgm), .arr_erase(arr_erase), .arr_mass(arr_mass), .arr_hv(arr_hv),
      .arr_prog_stb(arr_prog_stb), .arr_addr(arr_addr), .arr_data(arr_data), .standby(standby),
      .hv_refused(hv_refused));
   flrpp_link_chk u_flrpp_link_chk (
      .clk(clk), .rst_n(rst_n), .ctl_wr(lnk.ctl_wr), .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata),
      .prot_rd(lnk.prot_rd), .prot_vld(lnk.prot_vld), .arr_wr(lnk.arr_wr), .low_power(lnk.low_power));
   // Array side monitor: strobes and refused pump requests
   always @(posedge clk) begin
      if (arr_prog_stb === 1'b1) begin
         n_stb++;
         stb_a = arr_addr;
         stb_d = arr_data;
      end
      if (hv_refused === 1'b1) n_ref++;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One bus cycle; request held until waitrequest is sampled low
   task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (i = 0; i < 20000; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      if (i == 20000) begin
         n_fail++;
         test_done();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : av
   // Bounded poll of the status register until the sequence is over
   task automatic wait_idle();
      int i;
      for (i = 0; i < 20000; i++) begin
         av(REG_STATUS, 1'b0, 32'h0);
         if (q[ST_BUSY] === 1'b0) break;
      end
      if (i == 20000) begin
         n_fail++;
         test_done();
      end
   endtask : wait_idle
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Two bytes ending on the last byte of a row
      av(REG_ADDR, 1'b1, 32'h101E);
      av(REG_CMD, 1'b1, 32'({5'h01, 6'h00, OP_PROG}));
      av(REG_DATA, 1'b1, 32'hA5);
      av(REG_DATA, 1'b1, 32'h3C);
      wait_idle();
      chk("strobes", 32'(n_stb), 32'd2);
      chk("last addr", 32'(stb_a), 32'h101F);
      chk("last data", 32'(stb_d), 32'h3C);
      chk("status", 32'(q[15:0]), 32'hFF04);
      $display("test row program done");
      // Count crossing the row end is refused before any step
      av(REG_ADDR, 1'b1, 32'h101F);
      av(REG_CMD, 1'b1, 32'({5'h01, 6'h00, OP_PROG}));
      wait_idle();
      chk("row cross", 32'(q[3:0]), 32'h6);
      chk("row cross strobes", 32'(n_stb), 32'd2);
      $display("test row limit done");
      // Second byte never comes: byte wait runs out and the row is closed
      av(REG_ADDR, 1'b1, 32'h1040);
      av(REG_CMD, 1'b1, 32'({5'h01, 6'h00, OP_PROG}));
      av(REG_DATA, 1'b1, 32'h5A);
      wait_idle();
      chk("byte timeout", 32'(q[3:0]), 32'h6);
      chk("timeout strobes", 32'(n_stb), 32'd3);
      $display("test byte timeout done");
      // Protect codes, test voltage and mass erase inhibit
      e_stb = n_stb;
      e_ref = n_ref;
      for (int k = 0; k < 9; k++) begin
         c = CASES[k];
         bpr <= c[27:20];
         tst <= c[19];
         av(REG_ADDR, 1'b1, 32'(c[16:1]));
         av(REG_CMD, 1'b1, 32'(c[18:17]));
         if (c[18:17] == OP_PROG && !c[0]) av(REG_DATA, 1'b1, 32'(k));
         wait_idle();
         e_ref += c[0];
         e_stb += (c[18:17] == OP_PROG && !c[0]);
         chk("status", 32'(q[15:0]), 32'({c[27:20], 5'h00, 1'b1, c[0], 1'b0}));
         chk("refusals", 32'(n_ref), 32'(e_ref));
         chk("strobes", 32'(n_stb), 32'(e_stb));
      end
      $display("test protection done");
      // Low power during a page erase aborts into standby
      bpr <= 8'hFF;
      tst <= 1'b0;
      av(REG_ADDR, 1'b1, 32'h3000);
      av(REG_CMD, 1'b1, 32'(OP_PAGE));
      repeat (1300) @(posedge clk);
      low_power_req <= 1'b1;
      repeat (4) @(posedge clk);
      chk("standby", 32'(standby), 32'h1);
      chk("array controls", 32'({arr_pgm, arr_erase, arr_mass, arr_hv}), 32'h0);
      low_power_req <= 1'b0;
      wait_idle();
      chk("abort flag", 32'(q[ST_ABORT]), 32'h1);
      $display("test abort done");
      test_done();
   end
endmodule : testbench
